/* bvm_map.svh */
// register map, field positions, reset values and timing counts for the brownout monitor
// assumes a 32 kHz low-power oscillator level arriving as a pin, sampled on ref_clk
// Functional notes
// [R01] At every reset load level, active mode and sleep mode from the fuses.
// [R02] Threshold level and active mode follow the fuses; bus writes never change them.
// [R03] Sleep mode starts from its fuse value and software may overwrite it.
// [R04] Each mode is disabled, continuously enabled, or sampled once per period.
// [R05] Issue a system reset while the supply is below the brownout threshold.
// [R06] Entering standby or power-down sleep, the detector uses the sleep-mode field.
// [R07] Waking from deep sleep, the detector returns to the active-mode field.
// [R08] Writing one to the monitor interrupt enable turns the early warning monitor on.
// [R09] Request an interrupt on a threshold crossing in the selected direction.
// [R10] Monitor follows detector mode: off when detector off, sampled when sampled.
// [R11] Enabling the interrupt with selection 0x2 always sets the flag; here only while the detector is on.
// [R12] Monitor threshold comes from the software-written level offset field.
// [R13] In sampled mode only selection 0x1 may produce a monitor interrupt.
// [R14] The single monitor interrupt source sits at vector offset 0x00.
// [R15] An interrupt condition sets the matching flag in the flag register.
// [R16] Interrupt request stands while enable and flag are set, until flag clears.
// [R17] The detector runs from the 32 kHz ultra-low-power oscillator.
// [R18] Debug leaves detection alone but the monitor interrupt is held off while halted.
// [R19] Software writes the unlock key, then the sleep field within four instructions.
// [R20] Protected writes outside the unlock window complete on the bus but change nothing.
// [R21] Level offset 0x0 is five, 0x1 fifteen, 0x2 twenty-five percent; others reserved.
// [R22] Status bit reads one below the monitor threshold; valid only while detector on.
// [R23] Active setting 0x3 enables the detector and holds wake-up until it is ready.
// [R24] The monitor flag changes by hardware only while the detector is enabled.
// [R25] Writing one to the flag bit clears it; writing zero leaves it.
`ifndef BVM_MAP_SVH
`define BVM_MAP_SVH
// register indices; the byte address is four times the index
`define BVM_IDX_CTRLA      4'h0
`define BVM_IDX_CTRLB      4'h1
`define BVM_IDX_MONCTRL    4'h8
`define BVM_IDX_INTCTRL    4'h9
`define BVM_IDX_INTFLAGS   4'ha
`define BVM_IDX_STATUS     4'hb
// field positions
`define BVM_CTRLA_SAMP     4
`define BVM_CTRLA_ACT_LSB  2
`define BVM_CTRLA_SLP_LSB  0
`define BVM_INT_CFG_LSB    1
`define BVM_INT_IE         0
`define BVM_FLAG_BIT       0
// reset values of the software-owned registers
`define BVM_MONLVL_RST     2'h0
`define BVM_CFG_RST        2'h0
// crossing selections
`define BVM_CFG_FALL       2'h0
`define BVM_CFG_RISE       2'h1
`define BVM_CFG_BOTH       2'h2
// interrupt vector offset of the monitor source
`define BVM_VEC_MONITOR    8'h00
// sampling periods counted in oscillator ticks
`define BVM_OSC_HZ         32768
`define BVM_SAMP_FAST_HZ   1000
`define BVM_SAMP_SLOW_HZ   125
`define BVM_TICKS_FAST     (`BVM_OSC_HZ / `BVM_SAMP_FAST_HZ)
`define BVM_TICKS_SLOW     (`BVM_OSC_HZ / `BVM_SAMP_SLOW_HZ)
`endif

/* bvm_pkg.sv */
// types shared by the brownout monitor modules
// assumes bvm_map.svh supplies the numeric constants
package bvm_pkg;
  // detector operating modes, same encoding for active and sleep fields
  typedef enum logic [1:0] {
    BVM_OFF     = 2'b00,
    BVM_ON      = 2'b01,
    BVM_SAMPLED = 2'b10,
    BVM_ON_WAIT = 2'b11
  } bvm_mode_t;
  // sampling sequencer states
  typedef enum logic [1:0] {
    BVM_S_IDLE = 2'b00,
    BVM_S_WAIT = 2'b01,
    BVM_S_MEAS = 2'b10
  } bvm_samp_t;
  // configuration fuse contents
  typedef struct packed {
    logic       samp_rate;
    logic [1:0] active;
    logic [1:0] sleep;
    logic [2:0] level;
  } bvm_fuse_t;
  // drive to the analog comparators
  typedef struct packed {
    logic       det_enable;
    logic [2:0] det_level;
    logic [1:0] mon_level;
  } bvm_analog_t;
endpackage : bvm_pkg

/* bvm_sync3.sv */
// three-stage pin synchroniser; a bit changes once stages two and three agree
// assumes inputs come from outside the ref_clk domain
`timescale 1ns/100ps
module bvm_sync3 #(
  parameter int W = 4
) (
  // clock and control
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // pins in, clean levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] stg1;
  logic [W-1:0] stg2;
  logic [W-1:0] stg3;

  // shift chain; stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stg1 <= '0;
      stg2 <= '0;
      stg3 <= '0;
    end else if (ce) begin
      stg1 <= pin_in;
      stg2 <= stg1;
      stg3 <= stg2;
    end
  end

  // per-bit agreement filter rejects a single metastable sample
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_agree
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          level_out[g] <= 1'b0;
        end else if (ce && (stg2[g] == stg3[g])) begin
          level_out[g] <= stg3[g];
        end
      end
    end
  endgenerate
endmodule : bvm_sync3

/* bvm_top.sv */
// brownout detector and early warning monitor control with AHB-Lite registers
// assumes analog comparators and the 32 kHz oscillator arrive as asynchronous pins
`timescale 1ns/100ps
`include "bvm_map.svh"
module bvm_top
  import bvm_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // fuses and system state
  input  wire bvm_fuse_t    detector_config_fuse,
  input  wire logic         protected_write_gate,
  input  wire logic         deep_sleep,
  input  wire logic         cpu_halted,
  // analog side pins
  input  wire logic         ultra_low_power_osc,
  input  wire logic         supply_below_bod,
  input  wire logic         supply_below_monitor,
  input  wire logic         detector_ready,
  output bvm_analog_t       analog_ctl,
  // system outputs
  output logic              system_reset_req,
  output logic              wake_hold,
  output logic              monitor_irq,
  output logic [7:0]        monitor_irq_vector
);
  // register contents
  logic       sample_rate_select;
  bvm_mode_t  active_mode;
  bvm_mode_t  sleep_mode;
  logic [2:0] bod_level;
  logic [1:0] monitor_level_offset;
  logic [1:0] monitor_crossing_select;
  logic       monitor_irq_enable;
  logic       monitor_irq_flag;
  logic       monitor_below_status;
  // bus pipeline
  logic       wr_pend;
  logic       rd_pend;
  logic [3:0] addr_idx;
  logic       addr_ok;
  // synchronised pins
  logic [3:0] pin_lvl;
  logic       osc_lvl;
  logic       osc_prev;
  logic       osc_tick;
  logic       bod_low;
  logic       mon_low;
  logic       det_rdy;
  // sampling
  bvm_samp_t  samp_st;
  logic [8:0] samp_cnt;
  logic       meas_strobe;
  bvm_mode_t  mode_eff;
  logic       det_on;
  logic       crossing;
  logic       trig;
  logic       en_rise_set;

  // address decode shared by the write processes
  function automatic logic wr_hit(input logic [3:0] idx);
    return wr_pend && addr_ok && (addr_idx == idx);
  endfunction : wr_hit

  // register read mux, narrow data in the low byte
  function automatic logic [7:0] rd_mux(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == `BVM_IDX_CTRLA) begin
      v[`BVM_CTRLA_SAMP] = sample_rate_select;
      v[`BVM_CTRLA_ACT_LSB +: 2] = active_mode;
      v[`BVM_CTRLA_SLP_LSB +: 2] = sleep_mode;
    end else if (idx == `BVM_IDX_CTRLB) begin
      v[2:0] = bod_level;
    end else if (idx == `BVM_IDX_MONCTRL) begin
      v[1:0] = monitor_level_offset;
    end else if (idx == `BVM_IDX_INTCTRL) begin
      v[`BVM_INT_CFG_LSB +: 2] = monitor_crossing_select;
      v[`BVM_INT_IE] = monitor_irq_enable;
    end else if (idx == `BVM_IDX_INTFLAGS) begin
      v[`BVM_FLAG_BIT] = monitor_irq_flag;
    end else if (idx == `BVM_IDX_STATUS) begin
      v[0] = monitor_below_status;
    end
    return v;
  endfunction : rd_mux

  // bus front end: writes land in the data phase, reads take one wait state so
  // a read right behind a write sees the new value
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_idx  <= 4'h0;
      addr_ok   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend <= 1'b0;
      if (rd_pend) begin
        hrdata    <= addr_ok ? {24'h00_0000, rd_mux(addr_idx)} : 32'h0000_0000;
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
      end
      if (hready && hsel && htrans[1]) begin
        addr_idx <= haddr[5:2];
        addr_ok  <= (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'b00);
        if (hwrite) begin
          wr_pend <= 1'b1;
        end else begin
          rd_pend   <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // fuse-owned fields: loaded in reset, bus writes ignored
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sample_rate_select <= detector_config_fuse.samp_rate; // R01
      active_mode        <= bvm_mode_t'(detector_config_fuse.active); // R01
      bod_level          <= detector_config_fuse.level; // R01 R02
    end
  end

  // sleep mode: fuse at reset, then writable only inside the unlock window
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sleep_mode <= bvm_mode_t'(detector_config_fuse.sleep); // R01 R03
    end else if (ce && wr_hit(`BVM_IDX_CTRLA) && protected_write_gate) begin // R19 R20
      sleep_mode <= bvm_mode_t'(hwdata[`BVM_CTRLA_SLP_LSB +: 2]); // R03
    end
  end

  // software-owned monitor settings
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      monitor_level_offset    <= `BVM_MONLVL_RST;
      monitor_crossing_select <= `BVM_CFG_RST;
      monitor_irq_enable      <= 1'b0;
    end else if (ce) begin
      if (wr_hit(`BVM_IDX_MONCTRL)) begin
        monitor_level_offset <= hwdata[1:0]; // R12 R21
      end
      if (wr_hit(`BVM_IDX_INTCTRL)) begin
        monitor_crossing_select <= hwdata[`BVM_INT_CFG_LSB +: 2];
        monitor_irq_enable      <= hwdata[`BVM_INT_IE]; // R08
      end
    end
  end

  // pins cross into ref_clk
  bvm_sync3 #(.W(4)) u_sync (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .ce        (ce),
    .pin_in    ({detector_ready, supply_below_monitor, supply_below_bod,
                 ultra_low_power_osc}),
    .level_out (pin_lvl)
  );
  assign osc_lvl = pin_lvl[0];
  assign bod_low = pin_lvl[1];
  assign mon_low = pin_lvl[2];
  assign det_rdy = pin_lvl[3];

  // oscillator edge detect on the clean level
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      osc_prev <= 1'b0;
    end else if (ce) begin
      osc_prev <= osc_lvl;
    end
  end
  assign osc_tick = osc_lvl && !osc_prev; // R17

  // mode in force follows the sleep state; reserved sleep code counts as off
  always_comb begin
    if (deep_sleep) begin
      mode_eff = (sleep_mode == BVM_ON_WAIT) ? BVM_OFF : sleep_mode; // R06
    end else begin
      mode_eff = active_mode; // R07
    end
  end
  assign det_on = (mode_eff != BVM_OFF); // R04

  // sampled mode sequencer: wait one period, power the detector for one tick
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      samp_st  <= BVM_S_IDLE;
      samp_cnt <= 9'h000;
    end else if (ce) begin
      case (samp_st)
        BVM_S_IDLE: begin
          samp_cnt <= 9'h000;
          if (mode_eff == BVM_SAMPLED) begin
            samp_st <= BVM_S_WAIT; // R04
          end
        end
        BVM_S_WAIT: begin
          if (mode_eff != BVM_SAMPLED) begin
            samp_st <= BVM_S_IDLE;
          end else if (osc_tick) begin
            if (samp_cnt == 9'((sample_rate_select ? `BVM_TICKS_SLOW
                                                    : `BVM_TICKS_FAST) - 1)) begin
              samp_cnt <= 9'h000;
              samp_st  <= BVM_S_MEAS; // R17
            end else begin
              samp_cnt <= samp_cnt + 9'h001;
            end
          end
        end
        BVM_S_MEAS: begin
          if (mode_eff != BVM_SAMPLED) begin
            samp_st <= BVM_S_IDLE;
          end else if (osc_tick) begin
            samp_st <= BVM_S_WAIT;
          end
        end
        default: begin
          samp_st <= BVM_S_IDLE;
        end
      endcase
    end
  end

  // continuous modes look every cycle; sampled mode at the end of its window
  assign meas_strobe = (mode_eff == BVM_ON) || (mode_eff == BVM_ON_WAIT) ||
                       ((samp_st == BVM_S_MEAS) && osc_tick); // R10

  // analog drive; monitor comparator runs only with the detector
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      analog_ctl <= '0;
    end else if (ce) begin
      // a window still open as the mode drops to off must not power the detector
      analog_ctl.det_enable <= (mode_eff == BVM_ON) || (mode_eff == BVM_ON_WAIT) ||
                               ((mode_eff == BVM_SAMPLED) && (samp_st == BVM_S_MEAS)); // R04 R10
      analog_ctl.det_level  <= bod_level;
      analog_ctl.mon_level  <= monitor_level_offset; // R12 R21
    end
  end

  // brownout reset; a sampled low stands until a good sample or until the detector goes off
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      system_reset_req <= 1'b0;
    end else if (ce) begin
      if (!det_on) begin
        system_reset_req <= 1'b0;
      end else if (meas_strobe) begin
        system_reset_req <= bod_low; // R05
      end
    end
  end

  // wake-up stays held in mode 0x3 until the detector says ready
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wake_hold <= 1'b0;
    end else if (ce) begin
      wake_hold <= !deep_sleep && (active_mode == BVM_ON_WAIT) && !det_rdy; // R23
    end
  end

  // last known monitor comparison, frozen while the detector is off
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      monitor_below_status <= 1'b0;
    end else if (ce && det_on && meas_strobe) begin
      monitor_below_status <= mon_low; // R22
    end
  end

  // crossing classifier; sampled mode admits only selection 0x1
  assign crossing = det_on && meas_strobe && (mon_low != monitor_below_status);
  always_comb begin
    trig = 1'b0;
    if (crossing && monitor_irq_enable) begin // R08 R10
      if (mode_eff == BVM_SAMPLED) begin
        trig = (monitor_crossing_select == `BVM_CFG_RISE) && !mon_low; // R13
      end else if (monitor_crossing_select == `BVM_CFG_FALL) begin
        trig = mon_low; // R09
      end else if (monitor_crossing_select == `BVM_CFG_RISE) begin
        trig = !mon_low; // R09
      end else begin
        trig = (monitor_crossing_select == `BVM_CFG_BOTH); // R09
      end
    end
  end
  // turning the enable on with selection 0x2 raises the flag whenever the detector is on
  assign en_rise_set = det_on && wr_hit(`BVM_IDX_INTCTRL) && hwdata[`BVM_INT_IE] &&
                       !monitor_irq_enable &&
                       (hwdata[`BVM_INT_CFG_LSB +: 2] == `BVM_CFG_BOTH); // R11

  // flag: hardware set beats a same-cycle software clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      monitor_irq_flag <= 1'b0;
    end else if (ce) begin
      if (det_on && (trig || en_rise_set)) begin // R15 R24
        monitor_irq_flag <= 1'b1;
      end else if (wr_hit(`BVM_IDX_INTFLAGS) && hwdata[`BVM_FLAG_BIT]) begin
        monitor_irq_flag <= 1'b0; // R25
      end
    end
  end

  // request line; withheld while the core is halted in debug
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      monitor_irq        <= 1'b0;
      monitor_irq_vector <= `BVM_VEC_MONITOR;
    end else if (ce) begin
      monitor_irq        <= monitor_irq_flag && monitor_irq_enable && !cpu_halted; // R16 R18
      monitor_irq_vector <= `BVM_VEC_MONITOR; // R14
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_fuse_load;
    $rose(nrst) |-> (active_mode == bvm_mode_t'($past(detector_config_fuse.active)));
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("active mode not from fuse"); // R01

  property p_active_fixed;
    $past(nrst) |-> $stable(active_mode) && $stable(bod_level);
  endproperty
  a_active_fixed: assert property (p_active_fixed) else $error("fuse field changed"); // R02

  property p_sleep_locked;
    ce && wr_pend && !protected_write_gate |=> $stable(sleep_mode);
  endproperty
  a_sleep_locked: assert property (p_sleep_locked) else $error("locked write took"); // R20

  property p_sleep_write;
    ce && wr_hit(`BVM_IDX_CTRLA) && protected_write_gate
      |=> sleep_mode == bvm_mode_t'($past(hwdata[1:0]));
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("unlocked write lost"); // R03

  property p_bod_reset;
    ce && (mode_eff == BVM_ON) && bod_low |=> system_reset_req;
  endproperty
  a_bod_reset: assert property (p_bod_reset) else $error("no brownout reset"); // R05

  property p_irq_level;
    ce && monitor_irq_flag && monitor_irq_enable && !cpu_halted ##1 ce |-> monitor_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised"); // R16

  property p_flag_frozen;
    ce && !det_on && !wr_hit(`BVM_IDX_INTFLAGS) |=> $stable(monitor_irq_flag);
  endproperty
  a_flag_frozen: assert property (p_flag_frozen) else $error("flag moved while off"); // R24

  property p_flag_clear;
    ce && wr_hit(`BVM_IDX_INTFLAGS) && hwdata[0] && !trig && !en_rise_set
      |=> !monitor_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R25

  property p_off_quiet;
    ce && !det_on ##1 ce |-> !analog_ctl.det_enable;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("detector on in off mode"); // R10

  property p_read_wait;
    ce && hready && hsel && htrans[1] && !hwrite ##1 ce |-> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

  c_trig: cover property (trig);
  c_sample: cover property ((samp_st == BVM_S_MEAS) && osc_tick);
  c_read_flag: cover property (rd_pend && addr_idx == `BVM_IDX_INTFLAGS);
endmodule : bvm_top

/* bvm_analog_model.sv */
// comparator and oscillator stand-in facing the brownout monitor pins
// assumes the bench sets the supply in millivolts; the oscillator runs free
`timescale 1ns/100ps
module bvm_analog_model
  import bvm_pkg::*;
(
  // supply and comparator control
  input  wire logic [15:0] supply_mv,
  input  wire bvm_analog_t analog_ctl,
  // pins towards the design
  output logic             ultra_low_power_osc,
  output logic             supply_below_bod,
  output logic             supply_below_monitor,
  output logic             detector_ready
);
  int bod_mv;
  int mon_mv;
  int pct;
  // oscillator sped up so sampled periods stay short in simulation
  initial begin
    ultra_low_power_osc = 1'b0;
    forever #200 ultra_low_power_osc = ~ultra_low_power_osc;
  end
  // unpowered comparators give no steady answer, so they follow the oscillator
  always @(analog_ctl or supply_mv or ultra_low_power_osc) begin
    bod_mv = 1800 + 300 * analog_ctl.det_level;
    pct = (analog_ctl.mon_level == 2'h0) ? 105 : (analog_ctl.mon_level == 2'h1) ? 115 : 125;
    mon_mv = bod_mv * pct / 100;
    if (analog_ctl.det_enable) begin
      supply_below_bod     = supply_mv < bod_mv;
      supply_below_monitor = supply_mv < mon_mv;
    end else begin
      supply_below_bod     = ultra_low_power_osc;
      supply_below_monitor = ~ultra_low_power_osc;
    end
  end
  // ready comes some time after the detector is powered
  assign #100 detector_ready = analog_ctl.det_enable;
endmodule : bvm_analog_model

/* brownout_and_voltage_monitor_control_bench.sv */
// self-checking bench for the brownout monitor control block
// assumes bvm_analog_model stands at the analog pins; one slave drives hready
`timescale 1ns/100ps
module brownout_and_voltage_monitor_control_bench
  import bvm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  bvm_fuse_t   fuse = 8'h22;
  logic        gate = 1'b0;
  logic        deep_sleep = 1'b0;
  logic        halted = 1'b0;
  logic [15:0] supply_mv = 16'd3300;
  logic        osc;
  logic        below_bod;
  logic        below_mon;
  logic        ready;
  bvm_analog_t analog_ctl;
  logic        system_reset_req;
  logic        wake_hold;
  logic        monitor_irq;
  logic [7:0]  vec;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // design with the bus ready fed back from the single slave
  bvm_top dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .detector_config_fuse(fuse),
    .protected_write_gate(gate), .deep_sleep(deep_sleep), .cpu_halted(halted),
    .ultra_low_power_osc(osc), .supply_below_bod(below_bod),
    .supply_below_monitor(below_mon), .detector_ready(ready), .analog_ctl(analog_ctl),
    .system_reset_req(system_reset_req), .wake_hold(wake_hold),
    .monitor_irq(monitor_irq), .monitor_irq_vector(vec));
  bvm_analog_model model (.supply_mv(supply_mv), .analog_ctl(analog_ctl),
    .ultra_low_power_osc(osc), .supply_below_bod(below_bod),
    .supply_below_monitor(below_mon), .detector_ready(ready));

  // 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // a hang counts as a failure and ends the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // one single transfer; address held until hready, then data until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  task automatic t_reset();
    rd(32'h00, 32'h04);
    rd(32'h04, 32'h02);
    rd(32'h20, 32'h00);
    rd(32'h24, 32'h00);
    rd(32'h28, 32'h00);
    rd(32'h2c, 32'h00);
    rd(32'h40, 32'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_protect();
    wr(32'h00, 32'h0d);
    rd(32'h00, 32'h04);
    wr(32'h04, 32'h07);
    rd(32'h04, 32'h02);
    gate <= 1'b1;
    wr(32'h00, 32'h0d);
    gate <= 1'b0;
    rd(32'h00, 32'h05);
    gate <= 1'b1;
    wr(32'h00, 32'h00);
    gate <= 1'b0;
    rd(32'h00, 32'h04);
    $display("test protect done");
  endtask : t_protect

  task automatic t_level();
    supply_mv <= 16'd2800;
    wr(32'h20, 32'h02);
    tick(12);
    chk({30'h0, analog_ctl.mon_level}, 32'h2);
    chk({29'h0, analog_ctl.det_level}, 32'h2);
    rd(32'h2c, 32'h01);
    wr(32'h20, 32'h00);
    tick(12);
    rd(32'h2c, 32'h00);
    supply_mv <= 16'd3300;
    $display("test level done");
  endtask : t_level

  task automatic t_irq();
    wr(32'h24, 32'h01);
    tick(12);
    rd(32'h28, 32'h00);
    supply_mv <= 16'd2500;
    tick(12);
    rd(32'h28, 32'h01);
    chk({31'h0, monitor_irq}, 32'h1);
    chk({24'h0, vec}, 32'h0);
    // a clear sent while the clock enable is low must be lost
    ce <= 1'b0;
    wr(32'h28, 32'h01);
    ce <= 1'b1;
    rd(32'h28, 32'h01);
    halted <= 1'b1;
    tick(4);
    chk({31'h0, monitor_irq}, 32'h0);
    halted <= 1'b0;
    supply_mv <= 16'd3300;
    wr(32'h28, 32'h00);
    tick(12);
    rd(32'h28, 32'h01);
    chk({31'h0, monitor_irq}, 32'h1);
    wr(32'h28, 32'h01);
    rd(32'h28, 32'h00);
    chk({31'h0, monitor_irq}, 32'h0);
    wr(32'h24, 32'h00);
    wr(32'h24, 32'h05);
    tick(4);
    rd(32'h28, 32'h01);
    wr(32'h28, 32'h01);
    $display("test irq done");
  endtask : t_irq

  task automatic t_bod();
    supply_mv <= 16'd2300;
    tick(12);
    chk({31'h0, system_reset_req}, 32'h1);
    supply_mv <= 16'd3300;
    tick(12);
    chk({31'h0, system_reset_req}, 32'h0);
    $display("test bod done");
  endtask : t_bod

  task automatic t_sleep();
    wr(32'h28, 32'h01);
    deep_sleep <= 1'b1;
    tick(8);
    chk({31'h0, analog_ctl.det_enable}, 32'h0);
    tick(200);
    rd(32'h28, 32'h00);
    chk({31'h0, system_reset_req}, 32'h0);
    deep_sleep <= 1'b0;
    tick(8);
    chk({31'h0, analog_ctl.det_enable}, 32'h1);
    $display("test sleep done");
  endtask : t_sleep

  // sampled sleep mode with selection 0x2: a crossing is seen but raises nothing
  task automatic t_samp();
    int n;
    n = 0;
    wr(32'h28, 32'h01);
    gate <= 1'b1;
    wr(32'h00, 32'h02);
    gate <= 1'b0;
    supply_mv <= 16'd2450;
    deep_sleep <= 1'b1;
    tick(4);
    while (!analog_ctl.det_enable && n < 1000) begin
      tick(1);
      n++;
    end
    chk({31'h0, analog_ctl.det_enable}, 32'h1);
    tick(40);
    chk({31'h0, analog_ctl.det_enable}, 32'h0);
    chk({31'h0, system_reset_req}, 32'h0);
    rd(32'h2c, 32'h01);
    rd(32'h28, 32'h00);
    deep_sleep <= 1'b0;
    supply_mv <= 16'd3300;
    $display("test sampled done");
  endtask : t_samp

  // second reset with the wait-for-ready active mode in the fuse
  task automatic t_wake();
    fuse <= 8'h62;
    nrst <= 1'b0;
    tick(5);
    nrst <= 1'b1;
    tick(2);
    chk({31'h0, wake_hold}, 32'h1);
    tick(12);
    chk({31'h0, wake_hold}, 32'h0);
    rd(32'h00, 32'h0c);
    $display("test wake done");
  endtask : t_wake

  // reset for five cycles, then each test in turn
  initial begin
    tick(5);
    nrst <= 1'b1;
    tick(1);
    t_reset();
    t_protect();
    t_level();
    t_irq();
    t_bod();
    t_sleep();
    t_samp();
    t_wake();
    stop_test();
  end
endmodule : brownout_and_voltage_monitor_control_bench
